// *** core/ddrp_pkg.sv ***
package ddrp_pkg;

    localparam int DQ_W = 16;
    localparam int ROW_W = 13;
    localparam int BA_W = 2;
    localparam int LANES = 2;
    localparam int MEM_DEPTH = 16;
    localparam int IDX_W = 4;
    localparam logic [2:0] BURST_LEN = 3'h4;
    localparam logic [BA_W-1:0] EMR1_BANK = 2'h1;
    localparam int STROBE_DIFF_OFF_BIT = 10;
    localparam logic STROBE_DIFF_OFF_RST = 1'b1;
    localparam logic CKE_RST = 1'b0;

    // Command codes are {row strobe, column strobe, write enable} with select low.
    localparam logic [2:0] CODE_MODE = 3'h0;
    localparam logic [2:0] CODE_REFRESH = 3'h1;
    localparam logic [2:0] CODE_PRECHARGE = 3'h2;
    localparam logic [2:0] CODE_ACTIVATE = 3'h3;
    localparam logic [2:0] CODE_WRITE = 3'h4;
    localparam logic [2:0] CODE_READ = 3'h5;
    localparam logic [2:0] CODE_RESERVED = 3'h6;

    typedef enum logic [7:0] {
        CMD_NOP = 8'h01,
        CMD_ACTIVATE = 8'h02,
        CMD_READ = 8'h04,
        CMD_WRITE = 8'h08,
        CMD_PRECHARGE = 8'h10,
        CMD_REFRESH = 8'h20,
        CMD_MODE_SET = 8'h40,
        CMD_RESERVED = 8'h80
    } ddrp_cmd_t;

    typedef struct packed {
        ddrp_cmd_t kind;
        logic [BA_W-1:0] bank;
        logic [ROW_W-1:0] addr;
    } ddrp_evt_t;

    localparam int EVT_W = $bits(ddrp_evt_t);

    typedef struct packed {
        logic ck_t;
        logic ck_c;
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [BA_W-1:0] ba;
        logic [ROW_W-1:0] addr;
        logic [DQ_W-1:0] dq;
        logic [LANES-1:0] strb;
        logic [LANES-1:0] strb_c;
        logic [LANES-1:0] mask;
    } ddrp_pins_t;

endpackage : ddrp_pkg

// *** core/ddrp_buf2.sv ***
`timescale 1ns/1ps
`default_nettype none

// Two-entry buffer; entry 0 is always the head so the output comes from a flop.
module ddrp_buf2 #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    typedef struct packed {
        logic v0;
        logic v1;
        logic [W-1:0] d0;
        logic [W-1:0] d1;
    } ddrp_buf_st_t;

    ddrp_buf_st_t st_q;
    ddrp_buf_st_t st_d;

    assign in_ready = !st_q.v1;
    assign out_valid = st_q.v0;
    assign out_data = st_q.d0;

    always_comb
    begin
        st_d = st_q;
        if (st_q.v0 && out_ready)
        begin
            st_d.v0 = st_q.v1;
            st_d.d0 = st_q.d1;
            st_d.v1 = 1'b0;
        end
        if (in_valid && !st_q.v1)
        begin
            if (st_d.v0)
            begin
                st_d.v1 = 1'b1;
                st_d.d1 = in_data;
            end
            else
            begin
                st_d.v0 = 1'b1;
                st_d.d0 = in_data;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

endmodule : ddrp_buf2

`default_nettype wire

// *** core/ddrp_pin_if.sv ***
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Upper strobe goes out with read data and comes in with write data.
// - Read strobe edges align with data; write strobe edges sit mid-bit.
// - Complement strobe pins used only when extended mode register one enables them.
// - Chip select high at a clock crossing masks that command.
// - Chip select is not part of the command code; select low only lets the code be decoded.
// - Commands decode from row strobe, column strobe and write enable.
// - Write beats whose mask is high are not stored.
// - Masks are sampled on both strobe edges, one bit per beat.
// - Address and control are taken at the rising true-clock crossing.
// - Read data gives one beat per clock half-period.
// - Registered clock enable turns internal clocking on or off.
// - Lower strobe and mask serve the lower byte like the upper ones.
module ddrp_pin_if (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic link_clk,
    input wire logic ck_t,
    input wire logic ck_c,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [ddrp_pkg::BA_W-1:0] ba,
    input wire logic [ddrp_pkg::ROW_W-1:0] addr,
    input wire logic [ddrp_pkg::DQ_W-1:0] dq_in,
    output logic [ddrp_pkg::DQ_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic lower_byte_strobe_in,
    output logic lower_byte_strobe_out,
    output logic lower_byte_strobe_oe,
    input wire logic lower_byte_strobe_c_in,
    output logic lower_byte_strobe_c_out,
    output logic lower_byte_strobe_c_oe,
    input wire logic upper_byte_strobe_in,
    output logic upper_byte_strobe_out,
    output logic upper_byte_strobe_oe,
    input wire logic upper_byte_strobe_c_in,
    output logic upper_byte_strobe_c_out,
    output logic upper_byte_strobe_c_oe,
    input wire logic lower_byte_write_mask,
    input wire logic upper_byte_write_mask,
    output logic cmd_valid,
    input wire logic cmd_ready,
    output ddrp_pkg::ddrp_cmd_t cmd_kind,
    output logic [ddrp_pkg::BA_W-1:0] cmd_bank,
    output logic [ddrp_pkg::ROW_W-1:0] cmd_addr,
    output logic clock_active
);

    // Link-side state, clocked by the beat clock (two edges per memory clock period).
    typedef struct packed {
        // Two-flop synchroniser for every pin.
        ddrp_pkg::ddrp_pins_t p1;
        ddrp_pkg::ddrp_pins_t p2;
        // Acknowledge coming back from the core clock.
        logic ack1;
        logic ack2;
        // Crossing detector, registered clock enable and strobe mode.
        logic ck_prev;
        logic cke_q;
        logic diff_off_q;
        // Write bursts, tracked per byte lane.
        logic [ddrp_pkg::LANES-1:0] strb_prev;
        logic [ddrp_pkg::LANES-1:0][ddrp_pkg::IDX_W-1:0] wr_ptr;
        logic [ddrp_pkg::LANES-1:0][2:0] wr_left;
        logic [ddrp_pkg::MEM_DEPTH-1:0][ddrp_pkg::DQ_W-1:0] mem;
        // Read burst and the registered pin drivers.
        logic [ddrp_pkg::IDX_W-1:0] rd_ptr;
        logic [2:0] rd_left;
        logic [ddrp_pkg::DQ_W-1:0] dq_out;
        logic dq_oe;
        logic strb_out;
        logic strbc_out;
        logic strb_oe;
        logic strbc_oe;
        // Event for the core, held still until it is acknowledged.
        logic req;
        ddrp_pkg::ddrp_evt_t evt;
    } ddrp_link_st_t;

    // Core-side state on clk.
    typedef struct packed {
        logic req1;
        logic req2;
        logic seen;
        logic act1;
        logic act2;
    } ddrp_core_st_t;

    ddrp_link_st_t ln_q;
    ddrp_link_st_t ln_d;
    ddrp_core_st_t co_q;
    ddrp_core_st_t co_d;
    ddrp_pkg::ddrp_pins_t pins_now;
    ddrp_pkg::ddrp_evt_t buf_out;
    logic buf_in_ready;
    logic push;

    assign pins_now.ck_t = ck_t;
    assign pins_now.ck_c = ck_c;
    assign pins_now.cke = cke;
    assign pins_now.cs_n = cs_n;
    assign pins_now.ras_n = ras_n;
    assign pins_now.cas_n = cas_n;
    assign pins_now.we_n = we_n;
    assign pins_now.ba = ba;
    assign pins_now.addr = addr;
    assign pins_now.dq = dq_in;
    assign pins_now.strb = {upper_byte_strobe_in, lower_byte_strobe_in};
    assign pins_now.strb_c = {upper_byte_strobe_c_in, lower_byte_strobe_c_in};
    assign pins_now.mask = {upper_byte_write_mask, lower_byte_write_mask};

    function automatic ddrp_pkg::ddrp_cmd_t decode(input logic [2:0] code);
        ddrp_pkg::ddrp_cmd_t k;
        unique case (code)
            ddrp_pkg::CODE_MODE: k = ddrp_pkg::CMD_MODE_SET;
            ddrp_pkg::CODE_REFRESH: k = ddrp_pkg::CMD_REFRESH;
            ddrp_pkg::CODE_PRECHARGE: k = ddrp_pkg::CMD_PRECHARGE;
            ddrp_pkg::CODE_ACTIVATE: k = ddrp_pkg::CMD_ACTIVATE;
            ddrp_pkg::CODE_WRITE: k = ddrp_pkg::CMD_WRITE;
            ddrp_pkg::CODE_READ: k = ddrp_pkg::CMD_READ;
            ddrp_pkg::CODE_RESERVED: k = ddrp_pkg::CMD_RESERVED;
            default: k = ddrp_pkg::CMD_NOP;
        endcase
        return k;
    endfunction : decode

    // In differential mode a pair only reads high while true is high and complement low,
    // so a pair that is only half driven counts as low and cannot fake a strobe edge.
    function automatic logic strobe_level(input logic true_pin, input logic comp_pin, input logic single_ended);
        logic lvl;
        if (single_ended)
        begin
            lvl = true_pin;
        end
        else
        begin
            lvl = true_pin && !comp_pin;
        end
        return lvl;
    endfunction : strobe_level

    always_comb
    begin
        logic crossing;
        logic active;
        logic [ddrp_pkg::LANES-1:0] strb_lvl;
        ddrp_pkg::ddrp_cmd_t kind;
        crossing = 1'b0;
        active = 1'b0;
        strb_lvl = '0;
        kind = ddrp_pkg::CMD_NOP;
        ln_d = ln_q;
        ln_d.p1 = pins_now;
        ln_d.p2 = ln_q.p1;
        ln_d.ack1 = co_q.seen;
        ln_d.ack2 = ln_q.ack1;
        ln_d.ck_prev = ln_q.p2.ck_t;
        crossing = ln_q.p2.ck_t && !ln_q.p2.ck_c && !ln_q.ck_prev;
        if (crossing)
        begin
            ln_d.cke_q = ln_q.p2.cke;
        end
        active = crossing && ln_q.cke_q;
        if (active && !ln_q.p2.cs_n)
        begin
            kind = decode({ln_q.p2.ras_n, ln_q.p2.cas_n, ln_q.p2.we_n});
        end
        if (kind == ddrp_pkg::CMD_MODE_SET && ln_q.p2.ba == ddrp_pkg::EMR1_BANK)
        begin
            ln_d.diff_off_q = ln_q.p2.addr[ddrp_pkg::STROBE_DIFF_OFF_BIT];
        end
        // A new command only leaves when the previous one was acknowledged.
        // Commands arriving faster than the core can take them are dropped.
        if (kind != ddrp_pkg::CMD_NOP && ln_q.req == ln_q.ack2)
        begin
            ln_d.req = !ln_q.req;
            ln_d.evt.kind = kind;
            ln_d.evt.bank = ln_q.p2.ba;
            ln_d.evt.addr = ln_q.p2.addr;
        end

        // Write path: each byte lane follows its own strobe.
        for (int l = 0; l < ddrp_pkg::LANES; l++)
        begin
            strb_lvl[l] = strobe_level(ln_q.p2.strb[l], ln_q.p2.strb_c[l], ln_q.diff_off_q);
            ln_d.strb_prev[l] = strb_lvl[l];
            if (ln_q.wr_left[l] != 3'h0 && strb_lvl[l] != ln_q.strb_prev[l])
            begin
                if (!ln_q.p2.mask[l])
                begin
                    ln_d.mem[ln_q.wr_ptr[l]][8*l +: 8] = ln_q.p2.dq[8*l +: 8];
                end
                ln_d.wr_ptr[l] = ln_q.wr_ptr[l] + 4'h1;
                ln_d.wr_left[l] = ln_q.wr_left[l] - 3'h1;
            end
            if (kind == ddrp_pkg::CMD_WRITE)
            begin
                ln_d.wr_ptr[l] = ln_q.p2.addr[ddrp_pkg::IDX_W-1:0];
                ln_d.wr_left[l] = ddrp_pkg::BURST_LEN;
                ln_d.strb_prev[l] = 1'b0;
            end
        end

        // Read path: one beat per link cycle, strobe toggling with data.
        if (ln_q.rd_left != 3'h0)
        begin
            ln_d.dq_out = ln_q.mem[ln_q.rd_ptr];
            ln_d.dq_oe = 1'b1;
            ln_d.strb_out = !ln_q.strb_out;
            ln_d.strbc_out = ln_q.strb_out;
            ln_d.strb_oe = 1'b1;
            ln_d.strbc_oe = !ln_q.diff_off_q;
            ln_d.rd_ptr = ln_q.rd_ptr + 4'h1;
            ln_d.rd_left = ln_q.rd_left - 3'h1;
        end
        else
        begin
            ln_d.dq_oe = 1'b0;
            ln_d.strb_out = 1'b0;
            ln_d.strbc_out = 1'b1;
            ln_d.strb_oe = 1'b0;
            ln_d.strbc_oe = 1'b0;
        end
        if (kind == ddrp_pkg::CMD_READ)
        begin
            ln_d.rd_ptr = ln_q.p2.addr[ddrp_pkg::IDX_W-1:0];
            ln_d.rd_left = ddrp_pkg::BURST_LEN;
        end
    end

    always_ff @(posedge link_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ln_q <= '0;
            ln_q.cke_q <= ddrp_pkg::CKE_RST;
            ln_q.diff_off_q <= ddrp_pkg::STROBE_DIFF_OFF_RST;
            ln_q.strbc_out <= 1'b1;
        end
        else
        begin
            ln_q <= ln_d;
        end
    end

    // The core only acknowledges once the buffer has room, so a stalled user never loses the pending event.
    assign push = (co_q.req2 != co_q.seen) && buf_in_ready;

    always_comb
    begin
        co_d = co_q;
        co_d.req1 = ln_q.req;
        co_d.req2 = co_q.req1;
        co_d.act1 = ln_q.cke_q;
        co_d.act2 = co_q.act1;
        if (push)
        begin
            co_d.seen = co_q.req2;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            co_q <= '0;
        end
        else
        begin
            co_q <= co_d;
        end
    end

    ddrp_buf2 #(
        .W(ddrp_pkg::EVT_W)
    ) u_buf (
        .clk(clk),
        .reset_n(reset_n),
        .in_valid(push),
        .in_ready(buf_in_ready),
        .in_data(ln_q.evt),
        .out_valid(cmd_valid),
        .out_ready(cmd_ready),
        .out_data(buf_out)
    );

    assign cmd_kind = buf_out.kind;
    assign cmd_bank = buf_out.bank;
    assign cmd_addr = buf_out.addr;
    assign clock_active = co_q.act2;
    assign dq_out = ln_q.dq_out;
    assign dq_oe = ln_q.dq_oe;
    assign lower_byte_strobe_out = ln_q.strb_out;
    assign upper_byte_strobe_out = ln_q.strb_out;
    assign lower_byte_strobe_oe = ln_q.strb_oe;
    assign upper_byte_strobe_oe = ln_q.strb_oe;
    assign lower_byte_strobe_c_out = ln_q.strbc_out;
    assign upper_byte_strobe_c_out = ln_q.strbc_out;
    assign lower_byte_strobe_c_oe = ln_q.strbc_oe;
    assign upper_byte_strobe_c_oe = ln_q.strbc_oe;

endmodule : ddrp_pin_if

`default_nettype wire

// *** tb/ddrp_sva.sv ***
`timescale 1ns/1ps
`default_nettype none

module ddrp_sva (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic link_clk,
    input wire logic cs_n,
    input wire logic cke,
    input wire logic dq_oe,
    input wire logic lower_byte_strobe_out,
    input wire logic lower_byte_strobe_oe,
    input wire logic lower_byte_strobe_c_oe,
    input wire logic lower_byte_strobe_c_out,
    input wire logic upper_byte_strobe_out,
    input wire logic upper_byte_strobe_oe,
    input wire logic upper_byte_strobe_c_out,
    input wire logic upper_byte_strobe_c_oe,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire ddrp_pkg::ddrp_cmd_t cmd_kind,
    input wire logic [ddrp_pkg::BA_W-1:0] cmd_bank,
    input wire logic [ddrp_pkg::ROW_W-1:0] cmd_addr,
    input wire logic clock_active
);
    a_oe_with_data: assert property (@(posedge link_clk) disable iff (!reset_n)
        upper_byte_strobe_oe == dq_oe && lower_byte_strobe_oe == dq_oe)
        else $error("strobe enable differs from data enable");
    a_lanes_match: assert property (@(posedge link_clk) disable iff (!reset_n)
        dq_oe |-> lower_byte_strobe_out == upper_byte_strobe_out && lower_byte_strobe_c_out == upper_byte_strobe_c_out)
        else $error("strobe lanes differ during read");
    a_strobe_toggles: assert property (@(posedge link_clk) disable iff (!reset_n)
        dq_oe && $past(dq_oe) |-> upper_byte_strobe_out != $past(upper_byte_strobe_out))
        else $error("strobe did not change with the data beat");
    a_first_beat: assert property (@(posedge link_clk) disable iff (!reset_n)
        $rose(dq_oe) |-> upper_byte_strobe_out)
        else $error("first read beat without rising strobe");
    a_burst_end: assert property (@(posedge link_clk) disable iff (!reset_n)
        dq_oe [*4] |=> !dq_oe && !upper_byte_strobe_out)
        else $error("read burst longer than four beats");
    a_comp_strobe: assert property (@(posedge link_clk) disable iff (!reset_n)
        upper_byte_strobe_c_oe |-> upper_byte_strobe_c_out != upper_byte_strobe_out && dq_oe && lower_byte_strobe_c_oe)
        else $error("complement strobe wrong or driven outside a read");
    a_select_gate: assert property (@(posedge link_clk) disable iff (!reset_n)
        $rose(dq_oe) |-> $past(!cs_n, 3) || $past(!cs_n, 4) || $past(!cs_n, 5) || $past(!cs_n, 6))
        else $error("read started without chip select");
    a_cmd_hold: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_valid && !cmd_ready |=> cmd_valid && $stable({cmd_kind, cmd_bank, cmd_addr}))
        else $error("command changed before it was taken");
    a_cmd_kind: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_valid |-> $onehot(cmd_kind) && cmd_kind != ddrp_pkg::CMD_NOP)
        else $error("forwarded command kind invalid");
    a_cke_follow: assert property (@(posedge clk) disable iff (!reset_n)
        ($rose(clock_active) |-> $past(cke, 2)) and ($fell(clock_active) |-> !$past(cke, 2)))
        else $error("clock activity does not follow clock enable");
    c_read_burst: cover property (@(posedge link_clk) disable iff (!reset_n) $rose(dq_oe));
    c_cmd_stall: cover property (@(posedge clk) disable iff (!reset_n) cmd_valid && !cmd_ready ##1 cmd_valid);
    c_diff_read: cover property (@(posedge link_clk) disable iff (!reset_n) upper_byte_strobe_c_oe);
endmodule : ddrp_sva

`default_nettype wire

// *** tb/ddrp_ctl_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Memory clock stands still between commands; released pins show inverted values.
module ddrp_ctl_model (
    input wire logic link_clk,
    output var ddrp_pkg::ddrp_pins_t p
);
    initial
    begin
        p = '0;
        p.ck_c = 1'b1;
        p.cs_n = 1'b1;
        {p.ras_n, p.cas_n, p.we_n} = 3'h7;
        p.strb_c = 2'h3;
    end

    task automatic send(input logic cke, input logic cs, input logic [2:0] code, input logic [1:0] ba,
        input logic [12:0] a);
        @(negedge link_clk);
        p.cke = cke;
        p.cs_n = cs;
        {p.ras_n, p.cas_n, p.we_n} = code;
        p.ba = ba;
        p.addr = a;
        @(negedge link_clk);
        p.ck_t = 1'b1;
        p.ck_c = 1'b0;
        @(negedge link_clk);
        p.ck_t = 1'b0;
        p.ck_c = 1'b1;
        @(negedge link_clk);
        p.cs_n = 1'b1;
        {p.ras_n, p.cas_n, p.we_n} = 3'h7;
        p.addr = ~a;
        // Idle time lets the previous command's acknowledge return before the next crossing.
        repeat (4) @(negedge link_clk);
    endtask : send

    task automatic beats(input logic [63:0] d, input logic [7:0] m, input logic diff);
        for (int i = 0; i < 4; i++)
        begin
            @(negedge link_clk);
            p.dq = d[16*i+:16];
            p.mask = m[2*i+:2];
            @(negedge link_clk);
            p.strb = ~p.strb;
            p.strb_c = diff ? ~p.strb : 2'h3;
            repeat (4) @(negedge link_clk);
        end
        p.dq = ~p.dq;
        p.mask = ~p.mask;
    endtask : beats
endmodule : ddrp_ctl_model

`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic reset_n = 1'b0;
    logic cmd_ready = 1'b0;
    logic stall = 1'b1;
    logic diff = 1'b0;
    int mismatches = 0;
    int n_checks = 0;
    int seed = 32'h245E3E46;
    ddrp_pkg::ddrp_pins_t p;
    logic [15:0] mem [16];
    logic [17:0] rd_q [$];
    logic [22:0] cmd_q [$];
    logic [15:0] dq_in, dq_out;
    logic dq_oe, cmd_valid, clock_active;
    logic lower_byte_strobe_out, lower_byte_strobe_oe, lower_byte_strobe_c_out, lower_byte_strobe_c_oe;
    logic upper_byte_strobe_out, upper_byte_strobe_oe, upper_byte_strobe_c_out, upper_byte_strobe_c_oe;
    ddrp_pkg::ddrp_cmd_t cmd_kind;
    logic [1:0] cmd_bank;
    logic [12:0] cmd_addr;
    logic [2:0] codes [5] = '{ddrp_pkg::CODE_ACTIVATE, ddrp_pkg::CODE_PRECHARGE, ddrp_pkg::CODE_REFRESH,
        ddrp_pkg::CODE_RESERVED, ddrp_pkg::CODE_MODE};
    ddrp_pkg::ddrp_cmd_t kinds [5] = '{ddrp_pkg::CMD_ACTIVATE, ddrp_pkg::CMD_PRECHARGE, ddrp_pkg::CMD_REFRESH,
        ddrp_pkg::CMD_RESERVED, ddrp_pkg::CMD_MODE_SET};

    assign dq_in = dq_oe ? dq_out : p.dq;

    ddrp_ctl_model ddrp_ctl_model_i (.link_clk, .p);
    ddrp_pin_if ddrp_pin_if_i (.clk, .reset_n, .link_clk, .ck_t(p.ck_t), .ck_c(p.ck_c), .cke(p.cke),
        .cs_n(p.cs_n), .ras_n(p.ras_n), .cas_n(p.cas_n), .we_n(p.we_n), .ba(p.ba), .addr(p.addr), .dq_in,
        .dq_out, .dq_oe, .lower_byte_strobe_in(lower_byte_strobe_oe ? lower_byte_strobe_out : p.strb[0]),
        .lower_byte_strobe_out, .lower_byte_strobe_oe,
        .lower_byte_strobe_c_in(lower_byte_strobe_c_oe ? lower_byte_strobe_c_out : p.strb_c[0]),
        .lower_byte_strobe_c_out, .lower_byte_strobe_c_oe,
        .upper_byte_strobe_in(upper_byte_strobe_oe ? upper_byte_strobe_out : p.strb[1]),
        .upper_byte_strobe_out, .upper_byte_strobe_oe,
        .upper_byte_strobe_c_in(upper_byte_strobe_c_oe ? upper_byte_strobe_c_out : p.strb_c[1]),
        .upper_byte_strobe_c_out, .upper_byte_strobe_c_oe, .lower_byte_write_mask(p.mask[0]),
        .upper_byte_write_mask(p.mask[1]), .cmd_valid, .cmd_ready, .cmd_kind, .cmd_bank, .cmd_addr, .clock_active);

    initial forever #12.5 clk = ~clk;
    initial
    begin
        #7;
        forever #16 link_clk = ~link_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        if (mismatches == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    task automatic cmd(input logic cke, input logic cs, input logic [2:0] code, input logic [1:0] ba,
        input logic [12:0] a, input logic fwd, input ddrp_pkg::ddrp_cmd_t k);
        // The link drops a command while the buffer is full, so wait until it has room.
        wait (!fwd || cmd_q.size() < 2);
        if (fwd)
            cmd_q.push_back({k, ba, a});
        ddrp_ctl_model_i.send(cke, cs, code, ba, a);
    endtask : cmd

    task automatic wr(input logic [3:0] a, input logic [7:0] m);
        logic [63:0] d;
        d = {$random(seed), $random(seed)};
        for (int i = 0; i < 8; i++)
            if (!m[i])
                mem[4'(a + i / 2)][8 * (i % 2)+:8] = d[8 * i+:8];
        cmd(1'b1, 1'b0, ddrp_pkg::CODE_WRITE, 2'h0, {9'h0, a}, 1'b1, ddrp_pkg::CMD_WRITE);
        ddrp_ctl_model_i.beats(d, m, diff);
    endtask : wr

    task automatic rd(input logic [3:0] a);
        for (int i = 0; i < 4; i++)
            rd_q.push_back({diff, i % 2 == 0, mem[4'(a + i)]});
        cmd(1'b1, 1'b0, ddrp_pkg::CODE_READ, 2'h0, {9'h0, a}, 1'b1, ddrp_pkg::CMD_READ);
    endtask : rd

    task automatic drain();
        for (int k = 0; k < 400 && cmd_q.size() + rd_q.size() != 0; k++)
            @(posedge clk);
        check(cmd_q.size() + rd_q.size(), 0);
    endtask : drain

    always @(negedge clk)
        cmd_ready <= !stall && 1'($random(seed));

    always @(posedge clk)
        if (cmd_valid === 1'b1 && cmd_ready === 1'b1)
            check({cmd_kind, cmd_bank, cmd_addr}, cmd_q.size() ? cmd_q.pop_front() : 23'h7FFFFF);

    always @(negedge link_clk)
        if (dq_oe === 1'b1)
            check({upper_byte_strobe_c_oe, upper_byte_strobe_out, dq_out},
                rd_q.size() ? rd_q.pop_front() : 18'hX);

    initial
    begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        check(clock_active, 1'b0);
        cmd(1'b1, 1'b0, 3'h7, 2'h0, 13'h0, 1'b0, ddrp_pkg::CMD_NOP);
        repeat (8) @(negedge clk);
        check(clock_active, 1'b1);
        for (int i = 0; i < 5; i++)
        begin
            stall = i < 2;
            cmd(1'b1, 1'b0, codes[i], 2'(i), 13'($random(seed)), 1'b1, kinds[i]);
        end
        stall = 1'b0;
        cmd(1'b1, 1'b1, ddrp_pkg::CODE_READ, 2'h0, 13'h0, 1'b0, ddrp_pkg::CMD_READ);
        wr(4'hE, 8'h00);
        wr(4'hF, 8'h39);
        // The last write leaves both masks high, so this read also runs with masks set.
        rd(4'hE);
        drain();
        cmd(1'b0, 1'b0, 3'h7, 2'h0, 13'h0, 1'b0, ddrp_pkg::CMD_NOP);
        cmd(1'b0, 1'b0, ddrp_pkg::CODE_ACTIVATE, 2'h1, 13'h5, 1'b0, ddrp_pkg::CMD_ACTIVATE);
        repeat (8) @(negedge clk);
        check(clock_active, 1'b0);
        cmd(1'b1, 1'b0, 3'h7, 2'h0, 13'h0, 1'b0, ddrp_pkg::CMD_NOP);
        cmd(1'b1, 1'b0, ddrp_pkg::CODE_MODE, ddrp_pkg::EMR1_BANK, 13'h0, 1'b1, ddrp_pkg::CMD_MODE_SET);
        diff = 1'b1;
        wr(4'h6, 8'h00);
        rd(4'h6);
        cmd(1'b1, 1'b0, ddrp_pkg::CODE_MODE, ddrp_pkg::EMR1_BANK, 13'h400, 1'b1, ddrp_pkg::CMD_MODE_SET);
        diff = 1'b0;
        rd(4'h6);
        drain();
        report_and_stop();
    end

    initial
    begin
        #60000;
        mismatches++;
        report_and_stop();
    end
endmodule : tb

bind ddrp_pin_if ddrp_sva ddrp_sva_i (.*);

`default_nettype wire
